// [include/mds_pkg.sv]
// Purpose: Shared constants, types and register map of the motor drive supervisor.
// Assumes: 20 MHz system clock, 12-bit converter codes.
// Notes:   Scaled quantities use rpm, 0.1 V and mA units.
package mds_pkg;

   // Timing
   localparam int unsigned CLK_PERIOD_NS = 32'h32;        // 50 ns
   localparam int unsigned CHECK_PERIOD_US = 32'h64;      // 100 us
   localparam int unsigned CHECK_CYCLES = (CHECK_PERIOD_US * 32'h3e8) / CLK_PERIOD_NS;
   localparam int unsigned SLOW_PERIOD_US = 32'h3e8;      // 1 ms
   localparam int unsigned SLOW_CYCLES = (SLOW_PERIOD_US * 32'h3e8) / CLK_PERIOD_NS;
   localparam int unsigned CARRIER_FREQ_HZ = 32'h4e20;    // 20 kHz
   localparam int unsigned CARRIER_HALF_CYCLES =
      32'h3b9aca00 / (CLK_PERIOD_NS * CARRIER_FREQ_HZ * 32'h2);
   localparam int unsigned CARRIER_W = 10;

   // Converter codes
   localparam logic [11:0] ADC_FULL = 12'hfff;
   localparam logic [11:0] ADC_MID = 12'h800;
   localparam logic [10:0] SPEED_SPAN = 11'h7ff;          // 0800h..0fffh and 07ffh..0000h

   // Scaling and limits
   localparam logic [11:0] SPEED_REF_MAX_RPM = 12'ha8c;   // 2700 rpm
   localparam logic [10:0] BUS_FULL_DV = 11'h456;         // 111 V
   localparam logic [14:0] CUR_SPAN_MA = 15'h4e20;        // -10 A .. +10 A
   localparam logic signed [15:0] CUR_OFFSET_MA = 16'sh2710;
   localparam logic [16:0] OC_LIMIT_MA = 17'h0037a;       // 0.89 A
   localparam logic [10:0] OV_LIMIT_DV = 11'h118;         // 28 V
   localparam logic [10:0] UV_LIMIT_DV = 11'h08c;         // 14 V
   localparam logic [15:0] OSPD_LIMIT_RPM = 16'h0bb8;     // 3000 rpm

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CMP_U = 8'h08;
   localparam logic [7:0] REG_CMP_V = 8'h0c;
   localparam logic [7:0] REG_CMP_W = 8'h10;
   localparam logic [7:0] REG_VCMD = 8'h14;
   localparam logic [7:0] REG_MODF = 8'h18;
   localparam logic [7:0] REG_SPEED = 8'h1c;
   localparam logic [7:0] REG_VBUS = 8'h20;
   localparam logic [7:0] REG_IU = 8'h24;
   localparam logic [7:0] REG_IW = 8'h28;
   localparam logic [7:0] REG_STARTUP = 8'h2c;

   // Control register bits (write one to raise the event)
   localparam int unsigned CTRL_RUN_BIT = 0;
   localparam int unsigned CTRL_STOP_BIT = 1;
   localparam int unsigned CTRL_RESET_BIT = 2;

   // Reset values and saturated modulation factor
   localparam logic [CARRIER_W-1:0] CMP_RESET = 10'h000;
   localparam logic [11:0] VCMD_RESET = 12'h000;
   localparam logic [15:0] MODF_SATURATED = 16'hffff;

   typedef enum logic [2:0] {
      SYS_STOPPED = 3'b001,
      SYS_RUNNING = 3'b010,
      SYS_FAULT = 3'b100
   } mds_sys_mode_t;

   typedef enum logic [2:0] {
      RUN_BOOT = 3'b001,
      RUN_STARTUP = 3'b010,
      RUN_DRIVE = 3'b100
   } mds_run_mode_t;

   typedef enum logic [3:0] {
      STEP_ZERO = 4'b0001,
      STEP_RAMP = 4'b0010,
      STEP_HOLD = 4'b0100,
      STEP_DONE = 4'b1000
   } mds_step_t;

   typedef struct packed {
      logic [11:0] speedRef;
      logic [11:0] busVolt;
      logic [11:0] curU;
      logic [11:0] curW;
   } mds_adc_t;

   typedef struct packed {
      logic hwOc;
      logic swOc;
      logic ov;
      logic uv;
      logic ospd;
   } mds_fault_t;

endpackage

// [src/mds_pwm_phase.sv]
// Purpose: One PWM phase output by carrier comparison, with tri-state enable.
// Assumes: Carrier and compare share the same scale.
// Notes:   Output holds its level while compare equals carrier.
`timescale 1ns/100ps
module mds_pwm_phase #(
   parameter int unsigned CW = 10
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [CW-1:0] carrier,
   input wire logic [CW-1:0] compare,
   input wire logic enable,
   output logic pwmOut,
   output logic pwmOe
);

   logic cmpAbove;
   logic cmpBelow;

   assign cmpAbove = compare > carrier;
   assign cmpBelow = compare < carrier;

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pwmOut <= 1'b0;
         pwmOe <= 1'b0;
      end else begin
         pwmOe <= enable;
         if (!enable) begin
            pwmOut <= 1'b0;
         end else if (cmpAbove) begin
            pwmOut <= 1'b1;
         end else if (cmpBelow) begin
            pwmOut <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_pwm_on_above: assert property (enable && cmpAbove |=> pwmOut && pwmOe)
      else $error("phase not on while command above carrier");
   a_pwm_off_below: assert property (cmpBelow |=> !pwmOut)
      else $error("phase not off while command below carrier");

endmodule

// [src/mds_supervisor.sv]
// Purpose: Motor drive supervisor: scaling, carrier PWM, modes and protection.
// Assumes: Converter samples arrive with a one-cycle valid strobe; speed comes from outside.
// Notes:   Registers on classic Wishbone, one cycle to ack.
// Summary of operation
// - CW: codes 0800h up to 0fffh give 0 to 2700 rpm.
// - CCW: codes 07ffh down to 0000h give 0 to 2700 rpm.
// - Bus voltage code scales linearly from 0 V to 111 V.
// - Bus voltage feeds modulation and voltage checks; abnormality stops PWM.
// - U and W current codes scale linearly from -10 A to +10 A.
// - Phase output on while command exceeds carrier, off below it.
// - Modulation factor is voltage command divided by bus voltage.
// - Duty is set by loading each phase compare register.
// - System mode is stopped, running or fault; changes only on events.
// - Run mode advances only while system mode is running.
// - Fault event is internal; run, stop, reset come from operator commands.
// - Hardware over-current stop puts all PWM pins at high impedance.
// - Phase currents above 0.89 A, checked every 100 us, stop the drive.
// - Bus voltage above 28 V, checked every 100 us, stops the drive.
// - Bus voltage below 14 V, checked every 100 us, stops the drive.
// - Speed above 3000 rpm, checked every 100 us, stops the drive.
// - Startup d, q current and speed references each have own status.
`timescale 1ns/100ps
module mds_supervisor import mds_pkg::*; #(
   parameter int unsigned SLOW_TICK_CYCLES = SLOW_CYCLES,
   parameter int unsigned CHECK_TICK_CYCLES = CHECK_CYCLES
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire mds_adc_t adcSample,
   input wire logic adcValid,
   input wire logic [15:0] rotorSpeedRpm,
   input wire logic startStopSw_n,
   input wire logic ocStop_n,
   output logic [2:0] pwmOut,
   output logic [2:0] pwmOe,
   output logic faultActive_r
);

   localparam int unsigned CHK_W = $clog2(CHECK_TICK_CYCLES);
   localparam int unsigned SLOW_W = $clog2(SLOW_TICK_CYCLES);

   function automatic logic signed [15:0] toMilliAmp(input logic [11:0] code);
      logic [26:0] prod;
      logic [26:0] quot;
      prod = 27'(code) * 27'(CUR_SPAN_MA);
      quot = prod / 27'(ADC_FULL);
      return $signed({1'b0, quot[14:0]}) - CUR_OFFSET_MA;
   endfunction

   function automatic logic [16:0] absVal(input logic signed [16:0] v);
      return v[16] ? 17'(-v) : 17'(v);
   endfunction

   function automatic mds_step_t stepNext(input mds_step_t s, input logic go);
      mds_step_t n;
      n = s;
      if (go) begin
         unique case (s)
            STEP_ZERO: n = STEP_RAMP;
            STEP_RAMP: n = STEP_HOLD;
            STEP_HOLD: n = STEP_DONE;
            STEP_DONE: n = STEP_DONE;
            default: n = STEP_ZERO;
         endcase
      end
      return n;
   endfunction

   mds_sys_mode_t sysMode_r, sysMode_nxt;
   mds_run_mode_t runMode_r, runMode_nxt;
   mds_step_t idStat_r, iqStat_r, spdStat_r;
   mds_fault_t fault_r, faultSet;
   logic [CARRIER_W-1:0] cmp_r [3];
   logic [11:0] vCmd_r;
   logic [15:0] modFactor_r;
   logic [11:0] speedRefRpm_r;
   logic speedCcw_r;
   logic [10:0] busDv_r;
   logic signed [15:0] curU_r, curW_r;
   logic [CARRIER_W-1:0] carrier_r;
   logic carrierDown_r;
   logic [CHK_W-1:0] chkCnt_r;
   logic [SLOW_W-1:0] slowCnt_r;
   logic swPrev_r;

   // Bus decode
   logic busReq, writeStb, ctrlWr;
   logic [31:0] selMask, rdData;
   assign busReq = cyc_i & stb_i & ~ack_o;
   assign writeStb = busReq & we_i;
   assign ctrlWr = writeStb & (adr_i == REG_CTRL) & sel_i[0];
   assign selMask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};

   // Operator events from switch edges and control writes
   logic evRun, evStop, evReset, swStart, swStop;
   // Falling edge starts, rising edge stops
   assign swStart = swPrev_r & ~startStopSw_n;
   assign swStop = ~swPrev_r & startStopSw_n;
   assign evRun = (ctrlWr & dat_i[CTRL_RUN_BIT]) | swStart;
   assign evStop = (ctrlWr & dat_i[CTRL_STOP_BIT]) | swStop;
   assign evReset = ctrlWr & dat_i[CTRL_RESET_BIT];

   // Scaling of converter samples
   logic [10:0] spdMag;
   logic [22:0] spdProd, busProd;
   logic [11:0] spdRpm;
   logic [10:0] busDv;
   // Upper half is CW, lower half CCW
   assign spdMag = adcSample.speedRef[11] ? adcSample.speedRef[10:0] : ~adcSample.speedRef[10:0];
   assign spdProd = 23'(spdMag) * 23'(SPEED_REF_MAX_RPM);
   assign spdRpm = 12'(spdProd / 23'(SPEED_SPAN));
   // 0..111 V in 0.1 V steps
   assign busProd = 23'(adcSample.busVolt) * 23'(BUS_FULL_DV);
   assign busDv = 11'(busProd / 23'(ADC_FULL));

   // Protection
   logic running, chkTick, slowTick;
   logic signed [16:0] curV;
   logic swOcHit, ovHit, uvHit, ospdHit, errEvent;
   assign running = (sysMode_r == SYS_RUNNING);
   assign chkTick = (chkCnt_r == CHK_W'(CHECK_TICK_CYCLES - 1));
   assign slowTick = (slowCnt_r == SLOW_W'(SLOW_TICK_CYCLES - 1));
   assign curV = -(17'(curU_r) + 17'(curW_r));
   // All three phases against the current limit
   assign swOcHit = (absVal(17'(curU_r)) > OC_LIMIT_MA) | (absVal(17'(curW_r)) > OC_LIMIT_MA)
                  | (absVal(curV) > OC_LIMIT_MA);
   assign ovHit = busDv_r > OV_LIMIT_DV;
   assign uvHit = busDv_r < UV_LIMIT_DV;
   assign ospdHit = rotorSpeedRpm > OSPD_LIMIT_RPM;
   assign faultSet.hwOc = ~ocStop_n;
   assign faultSet.swOc = chkTick & running & swOcHit;
   assign faultSet.ov = chkTick & running & ovHit;
   assign faultSet.uv = chkTick & running & uvHit;
   assign faultSet.ospd = chkTick & running & ospdHit;
   // Fault event raised only from detected errors
   assign errEvent = |faultSet;

   always_comb begin
      sysMode_nxt = sysMode_r;
      unique case (sysMode_r)
         SYS_STOPPED: begin
            if (errEvent) begin
               sysMode_nxt = SYS_FAULT;
            end else if (evRun) begin
               sysMode_nxt = SYS_RUNNING;
            end
         end
         SYS_RUNNING: begin
            if (errEvent) begin
               sysMode_nxt = SYS_FAULT;
            end else if (evStop) begin
               sysMode_nxt = SYS_STOPPED;
            end
         end
         SYS_FAULT: begin
            if (evReset && !errEvent) begin
               sysMode_nxt = SYS_STOPPED;
            end
         end
         default: sysMode_nxt = SYS_FAULT;
      endcase
   end

   // Run mode advances only while running
   logic allDone;
   assign allDone = (idStat_r == STEP_DONE) & (iqStat_r == STEP_DONE) & (spdStat_r == STEP_DONE);
   always_comb begin
      runMode_nxt = runMode_r;
      if (!running) begin
         runMode_nxt = RUN_BOOT;
      end else if (slowTick) begin
         unique case (runMode_r)
            RUN_BOOT: runMode_nxt = RUN_STARTUP;
            RUN_STARTUP: runMode_nxt = allDone ? RUN_DRIVE : RUN_STARTUP;
            RUN_DRIVE: runMode_nxt = RUN_DRIVE;
            default: runMode_nxt = RUN_BOOT;
         endcase
      end
   end

   logic [19:0] modQuot;
   assign modQuot = (busDv_r == 11'h000) ? 20'hfffff : {vCmd_r, 8'h00} / 20'(busDv_r);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sysMode_r <= SYS_STOPPED;
         runMode_r <= RUN_BOOT;
         faultActive_r <= 1'b0;
         swPrev_r <= 1'b1;
      end else begin
         sysMode_r <= sysMode_nxt;
         runMode_r <= runMode_nxt;
         faultActive_r <= (sysMode_nxt == SYS_FAULT);
         swPrev_r <= startStopSw_n;
      end
   end

   // Startup status for d, q and speed references; q steps once d reaches hold, speed once q does
   logic stepGo;
   assign stepGo = running & slowTick & (runMode_r == RUN_STARTUP);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         idStat_r <= STEP_ZERO;
         iqStat_r <= STEP_ZERO;
         spdStat_r <= STEP_ZERO;
      end else if (!running) begin
         idStat_r <= STEP_ZERO;
         iqStat_r <= STEP_ZERO;
         spdStat_r <= STEP_ZERO;
      end else begin
         idStat_r <= stepNext(idStat_r, stepGo);
         iqStat_r <= stepNext(iqStat_r, stepGo & (idStat_r inside {STEP_HOLD, STEP_DONE}));
         spdStat_r <= stepNext(spdStat_r, stepGo & (iqStat_r inside {STEP_HOLD, STEP_DONE}));
      end
   end

   // Faults are sticky; a new error wins over the reset event
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         fault_r <= '0;
      end else begin
         fault_r <= (evReset ? mds_fault_t'(5'h00) : fault_r) | faultSet;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         speedRefRpm_r <= 12'h000;
         speedCcw_r <= 1'b0;
         busDv_r <= 11'h000;
         curU_r <= 16'sh0000;
         curW_r <= 16'sh0000;
      end else if (adcValid) begin
         speedRefRpm_r <= spdRpm;
         speedCcw_r <= ~adcSample.speedRef[11];
         busDv_r <= busDv;
         curU_r <= toMilliAmp(adcSample.curU);
         curW_r <= toMilliAmp(adcSample.curW);
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         chkCnt_r <= '0;
         slowCnt_r <= '0;
         carrier_r <= '0;
         carrierDown_r <= 1'b0;
         modFactor_r <= 16'h0000;
      end else begin
         chkCnt_r <= chkTick ? '0 : chkCnt_r + 1'b1;
         slowCnt_r <= slowTick ? '0 : slowCnt_r + 1'b1;
         carrier_r <= carrierDown_r ? carrier_r - 1'b1 : carrier_r + 1'b1;
         if (!carrierDown_r && carrier_r == CARRIER_W'(CARRIER_HALF_CYCLES - 1)) begin
            carrierDown_r <= 1'b1;
         end else if (carrierDown_r && carrier_r == CARRIER_W'(1)) begin
            carrierDown_r <= 1'b0;
         end
         modFactor_r <= (modQuot > 20'h0ffff) ? MODF_SATURATED : modQuot[15:0];
      end
   end

   // Compare registers and voltage command written by software
   logic [31:0] wrMerge [4];
   assign wrMerge[0] = ({22'h0, cmp_r[0]} & ~selMask) | (dat_i & selMask);
   assign wrMerge[1] = ({22'h0, cmp_r[1]} & ~selMask) | (dat_i & selMask);
   assign wrMerge[2] = ({22'h0, cmp_r[2]} & ~selMask) | (dat_i & selMask);
   assign wrMerge[3] = ({20'h0, vCmd_r} & ~selMask) | (dat_i & selMask);
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmp_r[0] <= CMP_RESET;
         cmp_r[1] <= CMP_RESET;
         cmp_r[2] <= CMP_RESET;
         vCmd_r <= VCMD_RESET;
      end else if (writeStb) begin
         if (adr_i == REG_CMP_U) cmp_r[0] <= wrMerge[0][CARRIER_W-1:0];
         if (adr_i == REG_CMP_V) cmp_r[1] <= wrMerge[1][CARRIER_W-1:0];
         if (adr_i == REG_CMP_W) cmp_r[2] <= wrMerge[2][CARRIER_W-1:0];
         if (adr_i == REG_VCMD) vCmd_r <= wrMerge[3][11:0];
      end
   end

   always_comb begin
      unique case (adr_i)
         REG_STATUS: rdData = {19'h0, speedCcw_r, ~ocStop_n, fault_r, runMode_r, sysMode_r};
         REG_CMP_U: rdData = {22'h0, cmp_r[0]};
         REG_CMP_V: rdData = {22'h0, cmp_r[1]};
         REG_CMP_W: rdData = {22'h0, cmp_r[2]};
         REG_VCMD: rdData = {20'h0, vCmd_r};
         REG_MODF: rdData = {16'h0, modFactor_r};
         REG_SPEED: rdData = {20'h0, speedRefRpm_r};
         REG_VBUS: rdData = {21'h0, busDv_r};
         REG_IU: rdData = {16'h0, curU_r};
         REG_IW: rdData = {16'h0, curW_r};
         REG_STARTUP: rdData = {20'h0, spdStat_r, iqStat_r, idStat_r};
         default: rdData = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= busReq;
         dat_o <= (busReq && !we_i) ? rdData : 32'h0000_0000;
      end
   end

   // PWM enabled only while running without hardware stop
   logic pwmEnable;
   assign pwmEnable = running & ocStop_n & ~errEvent;
   for (genvar ph = 0; ph < 3; ph++) begin : gPhase
      mds_pwm_phase #(.CW(CARRIER_W)) uPhase (
         .clk_sys(clk_sys),
         .arst_n(arst_n),
         .carrier(carrier_r),
         .compare(cmp_r[ph]),
         .enable(pwmEnable),
         .pwmOut(pwmOut[ph]),
         .pwmOe(pwmOe[ph])
      );
   end

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   a_hw_stop_hiz: assert property (!ocStop_n |=> pwmOe == 3'b000)
      else $error("PWM driven during hardware stop");
   a_fault_pwm_off: assert property (sysMode_r == SYS_FAULT |=> pwmOe == 3'b000)
      else $error("PWM driven in fault");
   a_fault_exit_reset: assert property (sysMode_r == SYS_FAULT && !evReset
      |=> sysMode_r == SYS_FAULT)
      else $error("fault left without reset");
   a_run_needs_event: assert property (sysMode_r == SYS_STOPPED && !evRun
      |=> sysMode_r != SYS_RUNNING)
      else $error("run entered without run event");
   a_error_to_fault: assert property (errEvent |=> sysMode_r == SYS_FAULT)
      else $error("error did not raise fault");
   a_runmode_idle: assert property (!running |=> runMode_r == RUN_BOOT)
      else $error("run mode moved outside running");
   a_ov_trip: assert property (chkTick && running && busDv_r > OV_LIMIT_DV
      |=> fault_r.ov ##1 pwmOe == 3'b000)
      else $error("over-voltage not tripped");
   a_uv_trip: assert property (chkTick && running && busDv_r < UV_LIMIT_DV |=> fault_r.uv)
      else $error("under-voltage not tripped");
   a_oc_trip: assert property (chkTick && running && swOcHit
      |=> fault_r.swOc && faultActive_r)
      else $error("over-current not tripped");
   a_ospd_trip: assert property (chkTick && running && ospdHit |=> fault_r.ospd)
      else $error("over-speed not tripped");
   a_check_period: assert property (chkTick |=> !chkTick [*8])
      else $error("check tick too frequent");
   a_cw_full: assert property (adcValid && adcSample.speedRef == ADC_FULL
      |=> speedRefRpm_r == SPEED_REF_MAX_RPM && !speedCcw_r)
      else $error("CW full scale wrong");
   a_cw_mid: assert property (adcValid && adcSample.speedRef == ADC_MID
      |=> speedRefRpm_r == 12'h000)
      else $error("CW zero point wrong");
   a_ccw_zero: assert property (adcValid && adcSample.speedRef == 12'h000
      |=> speedRefRpm_r == SPEED_REF_MAX_RPM && speedCcw_r)
      else $error("CCW full scale wrong");
   a_bus_full: assert property (adcValid && adcSample.busVolt == ADC_FULL
      |=> busDv_r == BUS_FULL_DV)
      else $error("bus full scale wrong");
   a_cur_ends: assert property (adcValid && adcSample.curU == 12'h000
      |=> curU_r == -CUR_OFFSET_MA)
      else $error("current zero code wrong");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");

   c_reach_drive: cover property (runMode_r == RUN_STARTUP ##1 runMode_r == RUN_DRIVE);
   c_fault_entry: cover property (running ##1 sysMode_r == SYS_FAULT);
   c_fault_reset: cover property (sysMode_r == SYS_FAULT ##1 sysMode_r == SYS_STOPPED);
   c_switch_start: cover property (swStart ##1 running);

endmodule

// [verification/mds_plant_model.sv]
// Purpose: Converter side of the drive: sense channels sampled on a fixed rhythm.
// Assumes: Bench sets the channel codes; one sample strobe every 8 clocks.
// Notes:   Sample data is refreshed every clock, strobe is a one-cycle pulse.
`timescale 1ns/100ps
module mds_plant_model import mds_pkg::*; (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire mds_adc_t codes,
   output mds_adc_t adcSample,
   output logic adcValid
);
   logic [2:0] cnt_r;
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= 3'h0;
         adcValid <= 1'b0;
         adcSample <= '0;
      end else begin
         cnt_r <= cnt_r + 3'h1;
         adcValid <= (cnt_r == 3'h7);
         adcSample <= codes;
      end
   end
endmodule

// [verification/tb_top.sv]
// Purpose: Register level test of the motor drive supervisor.
// Assumes: Short tick parameters; converter model strobes every 8 clocks.
// Notes:   Expected values are computed from the scaling and limit rules.
`timescale 1ns/100ps
module tb_top import mds_pkg::*;;
   logic clk_sys = 1'b0, arst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, swN = 1'b1, ocN = 1'b1;
   logic ack, adcValid, faultOn;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, datO, rdat;
   logic [15:0] spd = 16'h0;
   logic [2:0] pwmOut, pwmOe;
   mds_adc_t codes = {12'h800, 12'h3c0, 12'h800, 12'h800}, adcSample;
   int n_errors = 0, samples_checked = 0, cu, cv, cw;
   logic [11:0] busT[4] = '{12'h410, 12'h200, 12'h3c0, 12'h3c0};
   logic [11:0] curT[4] = '{12'h800, 12'h800, 12'h8c0, 12'h800};
   logic [15:0] spdT[4] = '{16'h0, 16'h0, 16'h0, 16'h0c1c};
   int bitT[4] = '{8, 7, 9, 6};
   always #25 clk_sys = ~clk_sys;
   mds_plant_model plant (.clk_sys(clk_sys), .arst_n(arst_n), .codes(codes),
      .adcSample(adcSample), .adcValid(adcValid));
   mds_supervisor #(.SLOW_TICK_CYCLES(20), .CHECK_TICK_CYCLES(16)) dut (.clk_sys(clk_sys),
      .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(datO), .ack_o(ack), .adcSample(adcSample), .adcValid(adcValid),
      .rotorSpeedRpm(spd), .startStopSw_n(swN), .ocStop_n(ocN), .pwmOut(pwmOut),
      .pwmOe(pwmOe), .faultActive_r(faultOn));
   task end_sim;
      $display("checks=%0d errors=%0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_sys);
      end while (ack !== 1'b1);
      rdat = datO;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_sys);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      wbx(1'b0, a, 32'h0);
      chk(rdat & m, e);
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   function automatic logic [31:0] eSpd(logic [11:0] c);
      logic [10:0] m;
      m = c[11] ? c[10:0] : ~c[10:0];
      return (32'(m) * 2700) / 2047;
   endfunction
   function automatic logic [31:0] eBus(logic [11:0] c);
      return (32'(c) * 1110) / 4095;
   endfunction
   function automatic logic [31:0] eCur(logic [11:0] c);
      return {16'h0, 16'((32'(c) * 20000) / 4095 - 10000)};
   endfunction
   initial begin
      #(50 * 20000);
      n_errors++;
      end_sim;
   end
   initial begin
      logic [11:0] c;
      wt(4);
      arst_n <= 1'b1;
      rd(REG_STATUS, 32'h9, 32'h7ff);
      rd(REG_CMP_U, 32'h0);
      rd(8'hfc, 32'h0);
      foreach (busT[i]) begin
         c = (i == 0) ? 12'h000 : (i == 1) ? 12'h7ff : (i == 2) ? 12'h800 : 12'hfff;
         codes <= {c, c, c, c};
         wt(12);
         wbx(1'b1, REG_SPEED, 32'hfff);
         rd(REG_SPEED, eSpd(c));
         rd(REG_STATUS, {19'h0, ~c[11], 12'h0}, 32'h1000);
         rd(REG_VBUS, eBus(c));
         rd(REG_IU, eCur(c), 32'hffff);
         rd(REG_IW, eCur(c), 32'hffff);
      end
      codes <= {12'h800, 12'h3c0, 12'h800, 12'h800};
      wt(12);
      wbx(1'b1, REG_VCMD, 32'h100);
      rd(REG_MODF, 32'h10000 / eBus(12'h3c0));
      wbx(1'b1, REG_CTRL, 32'h1);
      wbx(1'b1, REG_CMP_U, 32'h3ff);
      wbx(1'b1, REG_CMP_W, 32'h0fa);
      rd(REG_STATUS, 32'h2, 32'h7);
      wt(400);
      rd(REG_STARTUP, 32'h888, 32'hfff);
      rd(REG_STATUS, 32'h22, 32'h3f);
      cu = 0;
      cv = 0;
      cw = 0;
      repeat (1000) begin
         @(negedge clk_sys);
         cu += pwmOut[0];
         cv += pwmOut[1];
         cw += pwmOut[2];
      end
      chk(32'(pwmOe), 32'h7);
      chk(32'(cu), 32'd1000);
      chk(32'(cv), 32'd0);
      chk(32'(cw >= 495 && cw <= 505), 32'h1);
      @(posedge clk_sys);
      ocN <= 1'b0;
      wt(3);
      @(negedge clk_sys);
      chk({pwmOe, faultOn}, 32'h1);
      @(posedge clk_sys);
      ocN <= 1'b1;
      wbx(1'b1, REG_CTRL, 32'h2);
      rd(REG_STATUS, 32'h4, 32'h7);
      chk(32'(pwmOe), 32'h0);
      wbx(1'b1, REG_CTRL, 32'h4);
      rd(REG_STATUS, 32'h1, 32'h7);
      foreach (busT[i]) begin
         wbx(1'b1, REG_CTRL, 32'h1);
         codes <= {12'h800, busT[i], curT[i], 12'h800};
         spd <= spdT[i];
         wt(60);
         rd(REG_STATUS, (32'h1 << bitT[i]) | 32'h4, 32'h7c7);
         chk({pwmOe, faultOn}, 32'h1);
         codes <= {12'h800, 12'h3c0, 12'h800, 12'h800};
         spd <= 16'h0;
         wt(12);
         wbx(1'b1, REG_CTRL, 32'h4);
         rd(REG_STATUS, 32'h1, 32'h7c7);
      end
      swN <= 1'b0;
      wt(3);
      rd(REG_STATUS, 32'h2, 32'h7);
      swN <= 1'b1;
      wt(3);
      rd(REG_STATUS, 32'h1, 32'h7);
      wbx(1'b1, REG_CTRL, 32'h1);
      rd(REG_STATUS, 32'h2, 32'h7);
      wbx(1'b1, REG_CTRL, 32'h2);
      rd(REG_STATUS, 32'h1, 32'h7);
      end_sim;
   end
endmodule
